// file: perf_cap_checker_properties.sv
// Assertions on the bus, sampling and freeze outputs of the capability bank
`timescale 1ns/1ns
module perf_cap_checker #(parameter GP_COUNTERS = 4) (
    // Clock, reset and bus
    input wire clk_i,
    input wire rst_i,
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [15:0] adr_i,
    input wire [31:0] dat_i,
    input wire [31:0] dat_o,
    input wire ack_o,
    // Strap and state outputs
    input wire overclock_i,
    input wire [7:0] global_counter_enables_o,
    input wire [63:0] sampling_enable_o,
    input wire sampling_to_trace_o,
    input wire branch_record_enable_o,
    input wire system_management_mode_o
);
    localparam [31:0] GP_MASK = (32'h1 << GP_COUNTERS) - 32'h1;
    wire req = cyc_i && stb_i;
    wire [12:0] loc = adr_i[14:2];
    reg frz;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Freeze bit as last written to debug control
    always @(posedge clk_i) begin
        if (rst_i) frz <= 1'b0;
        else if (ack_o && we_i && loc == 13'h0F4) frz <= dat_i[14];
    end
    property p_ack_once; ack_o |=> !ack_o; endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
    property p_ack_next; req && !ack_o |=> ack_o; endproperty
    a_ack_next: assert property (p_ack_next) else $error("request not answered next cycle");
    property p_samp_wr; ack_o && we_i && loc == 13'h3F1 |=> sampling_enable_o[31:0] == ($past(dat_i) & GP_MASK); endproperty
    a_samp_wr: assert property (p_samp_wr) else $error("sampling enable write wrong");
    property p_trace; sampling_to_trace_o == (sampling_enable_o[62:61] == 2'b01); endproperty
    a_trace: assert property (p_trace) else $error("trace routing mismatch");
    property p_freeze_in; $rose(system_management_mode_o) && frz |-> global_counter_enables_o == 8'h00 && !branch_record_enable_o; endproperty
    a_freeze_in: assert property (p_freeze_in) else $error("enables not frozen on entry");
    property p_resume; $fell(system_management_mode_o) && frz |-> global_counter_enables_o == 8'hFF; endproperty
    a_resume: assert property (p_resume) else $error("enables not set on resume");
    property p_unmapped; ack_o && !we_i && loc[11:0] == 12'h100 |-> dat_o == 32'h0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_oc_bit; ack_o && !we_i && loc == 13'h0F2 |-> dat_o[31] == overclock_i; endproperty
    a_oc_bit: assert property (p_oc_bit) else $error("overclock status bit wrong");
    c_freeze: cover property ($rose(system_management_mode_o) && frz);
    c_trace: cover property ($rose(sampling_to_trace_o));
    c_unmapped: cover property (ack_o && loc[11:0] == 12'h100);
endmodule
bind perf_capability_and_smm_freeze perf_cap_checker #(.GP_COUNTERS(GP_COUNTERS)) chk_u (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .overclock_i(overclock_i),
    .global_counter_enables_o(global_counter_enables_o), .sampling_enable_o(sampling_enable_o),
    .sampling_to_trace_o(sampling_to_trace_o), .branch_record_enable_o(branch_record_enable_o),
    .system_management_mode_o(system_management_mode_o));

// file: perf_cap_map.vh
// Register offsets and field positions of the monitoring capability bank
`ifndef PERF_CAP_MAP_VH
`define PERF_CAP_MAP_VH
// Register indices (byte address is four times the index)
`define IDX_BUS_FREQUENCY_CODE 12'h0CD
`define IDX_SAMPLING_ENABLE 12'h3F1
`define IDX_SAMPLING_DATA_GROUP_CONFIG 12'h3F2
`define IDX_PLATFORM_INFORMATION 12'h0F0
`define IDX_PLATFORM_IDENTIFICATION 12'h0F1
`define IDX_PERFORMANCE_STATE_REPORT 12'h0F2
`define IDX_MONITORING_CAPABILITY_WORD 12'h0F3
`define IDX_DEBUG_CONTROL 12'h0F4
`define IDX_GLOBAL_COUNTER_ENABLES 12'h0F5
`define IDX_SYSTEM_CONTROL 12'h0F6
// Each 64-bit register is seen as two words: index selects the register, half bit selects upper word
`define HALF_BIT 14
// Capability word fields
`define CAP_BRANCH_FMT_LSB 0
`define CAP_TRAP_BIT 6
`define CAP_REGSAVE_BIT 7
`define CAP_LAYOUT_LSB 8
`define CAP_FREEZE_BIT 12
`define CAP_FULL_WRITE_BIT 13
`define CAP_BASELINE_BIT 14
`define CAP_TOPDOWN_BIT 15
`define CAP_TRACE_OUT_BIT 16
// Platform fields
`define PLAT_RATIO_LSB 8
`define PLAT_ID_RATIO_LSB 8
`define PERF_RATIO_LSB 40
`define PERF_OVERCLOCK_BIT 31
// Debug control fields
`define DBG_BRANCH_RECORD_BIT 0
`define DBG_SINGLE_STEP_BIT 1
`define DBG_TRACE_MESSAGE_BIT 6
`define DBG_BRANCH_STORE_BIT 7
`define DBG_FREEZE_BIT 14
// Sampling output field in the sampling enable register
`define SAMP_OUT_LSB 61
`define SAMP_OUT_TRACE 2'h1
// Fixed counters begin here in the sampling enable register
`define SAMP_FIXED_LSB 32
`endif

// file: perf_capability_and_smm_freeze.v
// Monitoring capability, frequency enumeration and freeze-on-system-management register bank
// Operation
// - Platform information bits 15:8 hold bus ratio; frequency is ratio times 100 MHz.
// - On the earlier generation that ratio field is multiplied by 133.33 MHz.
// - Bus frequency register holds code in bits 2:0, or 3:0 on the later variant.
// - Overclock off: maximum bus ratio reads in platform identification bits 12:8.
// - Overclock on: maximum bus ratio reads in performance status bits 44:40.
// - Performance status bit 31 is read-only and reads 1 with overclock enabled.
// - Capability holds branch format 5:0, trap bit 6, register save 7, layout 11:8.
// - Capability bit 12 flags freeze support, bit 13 full-width counter alias.
// - With baseline bit 14, sampling enable at 3F1H: general from 0, fixed from 32.
// - With baseline every counter samples precise and non-precise events when enabled.
// - With baseline, data group configuration exists at 3F2H; layout code defines its bits.
// - Capability bit 15 reads 1 when top-down metrics register is provided.
// - With bit 16 and trace present, sampling output 01B routes records to trace.
// - Capability word exists only when identification bit 15 is 1; here identification bit 15 always reads 0 and CAP_PRESENT alone gates the word.
// - On interrupt with freeze: clear global enables, save debug control, mask branch fields.
// - On resume: set global enables to 1 and restore saved debug control.
//
// Our own choice: the Wishbone slave port.
`timescale 1ns/1ns
`include "perf_cap_map.vh"

module perf_capability_and_smm_freeze #(
    parameter GP_COUNTERS = 4,
    parameter FIXED_COUNTERS = 3,
    parameter [5:0] BRANCH_FMT = 6'h05,
    parameter TRAP_LIKE = 1'b1,
    parameter REG_SAVE = 1'b1,
    parameter [3:0] LAYOUT_CODE = 4'h4,
    parameter FREEZE_SUPPORT = 1'b1,
    parameter FULL_WRITE = 1'b1,
    parameter BASELINE = 1'b1,
    parameter TOPDOWN = 1'b1,
    parameter TRACE_OUT = 1'b1,
    parameter TRACE_PRESENT = 1'b1,
    parameter CAP_PRESENT = 1'b1,
    parameter [7:0] PLATFORM_RATIO = 8'h20,
    parameter [4:0] ID_RATIO = 5'h0A,
    parameter [3:0] BUS_FREQ_CODE = 4'h1,
    parameter WIDE_BUS_FREQ = 1'b1,
    parameter [31:0] DATA_CFG_MASK = 32'h0000000F
) (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Wishbone slave
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [15:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    output reg [31:0] dat_o,
    output reg ack_o,
    // Core events and straps
    input wire sys_mgmt_int_i,
    input wire resume_i,
    input wire overclock_i,
    input wire [4:0] overclock_ratio_i,
    // State toward the counters
    output reg [7:0] global_counter_enables_o,
    output reg [63:0] sampling_enable_o,
    output reg sampling_to_trace_o,
    output reg branch_record_enable_o,
    output reg system_management_mode_o
);
    localparam GCE_W = 8;

    // Synchronisers for pin inputs; the second stage feeds logic, with a delayed copy for interrupt and resume only; the first stage does not
    // The ratio strap is treated as static while overclock is on
    reg sint_m, sint_s, sint_d, resume_m, resume_s, resume_d, oc_m, oc_s;
    reg [4:0] ocr_m, ocr_s;
    always @(posedge clk_i) begin
        sint_m <= sys_mgmt_int_i;
        sint_s <= sint_m;
        sint_d <= sint_s;
        resume_m <= resume_i;
        resume_s <= resume_m;
        resume_d <= resume_s;
        oc_m <= overclock_i;
        oc_s <= oc_m;
        ocr_m <= overclock_ratio_i;
        ocr_s <= ocr_m;
    end

    // Rising edges of the synchronised interrupt and resume requests
    wire sint_edge = sint_s & ~sint_d;
    wire resume_edge = resume_s & ~resume_d;

    // Software-visible state
    reg [63:0] debug_control;
    reg [63:0] saved_debug;
    reg [63:0] sampling_enable;
    reg [63:0] data_cfg;
    reg [GCE_W-1:0] global_enables;
    reg in_sys_mgmt;
    // Set only when this entry actually froze, so a stale copy is never restored
    reg frozen;

    // Sampling enable mask: one bit per counter, plus output select
    wire [63:0] samp_mask;
    genvar g;
    generate
        for (g = 0; g < 64; g = g + 1) begin : gen_mask
            // General counters from bit 0, fixed counters from bit 32
            assign samp_mask[g] = BASELINE && ((g < GP_COUNTERS) ||
                (g >= `SAMP_FIXED_LSB && g < `SAMP_FIXED_LSB + FIXED_COUNTERS) ||
                (g >= `SAMP_OUT_LSB && g < `SAMP_OUT_LSB + 2));
        end
    endgenerate

    // Read-only capability word, built only from parameters
    wire [63:0] cap_word = CAP_PRESENT ? {47'h0, TRACE_OUT[0], TOPDOWN[0], BASELINE[0], FULL_WRITE[0],
        FREEZE_SUPPORT[0], LAYOUT_CODE, REG_SAVE[0], TRAP_LIKE[0], BRANCH_FMT} : 64'h0;

    // Platform information ratio in 15:8
    wire [63:0] plat_info = {48'h0, PLATFORM_RATIO, 8'h00};
    // Identification ratio only valid with overclock off
    wire [63:0] plat_id = {51'h0, (oc_s ? 5'h00 : ID_RATIO), 8'h00};
    // Status reports overclock flag and ratio
    wire [63:0] perf_stat = {19'h0, (oc_s ? ocr_s : 5'h00), 8'h00, oc_s, 31'h0};
    // Bus frequency code, three or four bits
    wire [63:0] bus_freq = {60'h0, (WIDE_BUS_FREQ ? BUS_FREQ_CODE[3] : 1'b0), BUS_FREQ_CODE[2:0]};

    // Decode
    wire [11:0] idx = adr_i[13:2];
    wire upper = adr_i[`HALF_BIT];
    wire req = cyc_i & stb_i & ~ack_o;
    wire wr = req & we_i;
    wire [31:0] byte_mask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};

    // Merge a write into one half of a 64-bit register
    function [63:0] merge;
        input [63:0] old;
        input [31:0] data;
        input [31:0] bm;
        input hi;
        begin
            if (hi) begin
                merge = {(old[63:32] & ~bm) | (data & bm), old[31:0]};
            end else begin
                merge = {old[63:32], (old[31:0] & ~bm) | (data & bm)};
            end
        end
    endfunction

    reg [63:0] rd64;
    always @* begin
        case (idx)
            `IDX_BUS_FREQUENCY_CODE: rd64 = bus_freq;
            `IDX_SAMPLING_ENABLE: rd64 = sampling_enable;
            `IDX_SAMPLING_DATA_GROUP_CONFIG: rd64 = data_cfg;
            `IDX_PLATFORM_INFORMATION: rd64 = plat_info;
            `IDX_PLATFORM_IDENTIFICATION: rd64 = plat_id;
            `IDX_PERFORMANCE_STATE_REPORT: rd64 = perf_stat;
            `IDX_MONITORING_CAPABILITY_WORD: rd64 = cap_word;
            `IDX_DEBUG_CONTROL: rd64 = debug_control;
            `IDX_GLOBAL_COUNTER_ENABLES: rd64 = {{(64-GCE_W){1'b0}}, global_enables};
            `IDX_SYSTEM_CONTROL: rd64 = {63'h0, in_sys_mgmt};
            default: rd64 = 64'h0;
        endcase
    end

    // Debug control bits software may write; freeze bit only when supported
    wire [63:0] dbg_wmask = {49'h0, FREEZE_SUPPORT[0], 6'h00, 8'hFF};
    wire [63:0] dbg_branch_mask = 64'h0 | (64'h1 << `DBG_BRANCH_RECORD_BIT) | (64'h1 << `DBG_SINGLE_STEP_BIT)
        | (64'h1 << `DBG_TRACE_MESSAGE_BIT) | (64'h1 << `DBG_BRANCH_STORE_BIT);
    wire freeze_on = debug_control[`DBG_FREEZE_BIT];
    // Global enables widened for the merge, then cut back on purpose
    wire [63:0] gce_merged = merge({{(64-GCE_W){1'b0}}, global_enables}, dat_i, byte_mask, upper);

    // Bus answer: one-cycle ack, read data registered
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0;
        end else begin
            ack_o <= req;
            if (req) begin
                dat_o <= upper ? rd64[63:32] : rd64[31:0];
            end
        end
    end

    // Register writes and freeze sequence
    always @(posedge clk_i) begin
        if (rst_i) begin
            debug_control <= 64'h0;
            saved_debug <= 64'h0;
            sampling_enable <= 64'h0;
            data_cfg <= 64'h0;
            global_enables <= {GCE_W{1'b0}};
            in_sys_mgmt <= 1'b0;
            frozen <= 1'b0;
        end else begin
            if (wr) begin
                case (idx)
                    `IDX_SAMPLING_ENABLE: sampling_enable <= merge(sampling_enable, dat_i, byte_mask, upper) & samp_mask;
                    // Only bits set in DATA_CFG_MASK are kept, and none without baseline
                    `IDX_SAMPLING_DATA_GROUP_CONFIG: data_cfg <= merge(data_cfg, dat_i, byte_mask, upper)
                        & (BASELINE ? {32'h0, DATA_CFG_MASK} : 64'h0);
                    `IDX_DEBUG_CONTROL: debug_control <= merge(debug_control, dat_i, byte_mask, upper) & dbg_wmask;
                    `IDX_GLOBAL_COUNTER_ENABLES: global_enables <= gce_merged[GCE_W-1:0];
                    default: ;
                endcase
            end
            // A freezing entry wins over a bus write in the same cycle, being assigned last
            if (sint_edge && !in_sys_mgmt) begin
                in_sys_mgmt <= 1'b1;
                frozen <= freeze_on;
                if (freeze_on) begin
                    global_enables <= {GCE_W{1'b0}};
                    saved_debug <= debug_control;
                    debug_control <= debug_control & ~dbg_branch_mask;
                end
            end else if (resume_edge && in_sys_mgmt) begin
                in_sys_mgmt <= 1'b0;
                frozen <= 1'b0;
                if (frozen) begin
                    global_enables <= {GCE_W{1'b1}};
                    debug_control <= saved_debug;
                end
            end
        end
    end

    // Outputs registered
    always @(posedge clk_i) begin
        if (rst_i) begin
            global_counter_enables_o <= 8'h00;
            sampling_enable_o <= 64'h0;
            sampling_to_trace_o <= 1'b0;
            branch_record_enable_o <= 1'b0;
            system_management_mode_o <= 1'b0;
        end else begin
            global_counter_enables_o <= global_enables;
            sampling_enable_o <= sampling_enable;
            // Route records to trace only when offered and trace present
            sampling_to_trace_o <= TRACE_OUT && TRACE_PRESENT &&
                (sampling_enable[`SAMP_OUT_LSB+1:`SAMP_OUT_LSB] == `SAMP_OUT_TRACE);
            branch_record_enable_o <= debug_control[`DBG_BRANCH_RECORD_BIT];
            system_management_mode_o <= in_sys_mgmt;
        end
    end
endmodule

// file: perf_capability_and_smm_freeze_tb.sv
// Self-checking bench for the capability and freeze register bank
`timescale 1ns/1ns
module perf_capability_and_smm_freeze_tb;
    logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, sys_mgmt_int_i = 0, resume_i = 0, overclock_i = 0;
    logic [15:0] adr_i = 0;
    logic [3:0] sel_i = 4'hF;
    logic [31:0] dat_i = 0, dat_o, q, d, e;
    logic [4:0] overclock_ratio_i = 0;
    logic ack_o, sampling_to_trace_o, branch_record_enable_o, system_management_mode_o;
    logic [7:0] global_counter_enables_o, v;
    logic [63:0] sampling_enable_o, x;
    logic [11:0] ro_idx [5] = '{12'h0F3, 12'h0F0, 12'h0F1, 12'h0CD, 12'h100};
    logic [31:0] ro_val [5] = '{32'h0001F4C5, 32'h2000, 32'h0A00, 32'h1, 32'h0};
    int n_errors = 0, n_checks = 0;
    always #10 clk_i = ~clk_i;
    perf_capability_and_smm_freeze dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .sys_mgmt_int_i(sys_mgmt_int_i), .resume_i(resume_i), .overclock_i(overclock_i),
        .overclock_ratio_i(overclock_ratio_i),
        .global_counter_enables_o(global_counter_enables_o), .sampling_enable_o(sampling_enable_o),
        .sampling_to_trace_o(sampling_to_trace_o), .branch_record_enable_o(branch_record_enable_o),
        .system_management_mode_o(system_management_mode_o));
    // Writable bits of the sampling enable register
    function automatic logic [63:0] samp_exp(input logic [63:0] raw);
        samp_exp = raw & 64'h6000_0007_0000_000F;
    endfunction
    task automatic report_and_stop;
        if (n_errors == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One classic bus cycle, ack awaited under a bound
    task automatic wb(input logic w, input logic [11:0] idx, input logic hi, input logic [31:0] wd);
        int k;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= {1'b0, hi, idx, 2'b00};
        dat_i <= wd;
        k = 0;
        // Ack and data are looked at once settled, released after the edge that sees ack
        do begin
            @(negedge clk_i);
            k++;
        end while (ack_o !== 1'b1 && k < 20);
        if (ack_o !== 1'b1) begin
            n_errors++;
            report_and_stop;
        end
        q = dat_o;
        @(posedge clk_i);
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] idx, input logic hi, input logic [31:0] exp);
        wb(1'b0, idx, hi, 32'h0);
        chk(q, exp);
    endtask
    initial begin
        #1000000;
        n_errors++;
        report_and_stop;
    end
    initial begin
        void'($urandom(49680));
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        // Read-only words ignore writes; unmapped reads zero
        for (int i = 0; i < 5; i++) begin
            wb(1'b1, ro_idx[i], 1'b0, $urandom);
            rd(ro_idx[i], 1'b0, ro_val[i]);
            rd(ro_idx[i], 1'b1, 32'h0);
        end
        // Sampling enable and data group configuration
        for (int i = 0; i < 8; i++) begin
            d = (i == 0) ? 32'h2000_0000 : $urandom;
            e = $urandom;
            x = samp_exp({d, e});
            wb(1'b1, 12'h3F1, 1'b0, e);
            wb(1'b1, 12'h3F1, 1'b1, d);
            rd(12'h3F1, 1'b1, x[63:32]);
            chk(sampling_enable_o, x);
            chk(sampling_to_trace_o, x[62:61] == 2'b01);
            wb(1'b1, 12'h3F2, 1'b0, e);
            rd(12'h3F2, 1'b0, e & 32'h0000_000F);
        end
        // Overclock status word
        d = $urandom;
        overclock_i <= 1'b1;
        overclock_ratio_i <= d[4:0];
        wb(1'b1, 12'h0F2, 1'b0, 32'h0);
        wb(1'b0, 12'h0F2, 1'b0, 32'h0);
        chk(q[31], 1'b1);
        wb(1'b0, 12'h0F2, 1'b1, 32'h0);
        chk(q[12:8], d[4:0]);
        overclock_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        wb(1'b0, 12'h0F2, 1'b0, 32'h0);
        chk(q[31], 1'b0);
        // Interrupt entry and resume, with and without freeze
        for (int f = 1; f >= 0; f--) begin
            d = ($urandom & 32'hFF) | 32'hC3 | (f << 14);
            v = 8'($urandom);
            wb(1'b1, 12'h0F4, 1'b0, d);
            wb(1'b1, 12'h0F5, 1'b0, {24'h0, v});
            sys_mgmt_int_i <= 1'b1;
            repeat (6) @(posedge clk_i);
            chk(global_counter_enables_o, f ? 8'h00 : v);
            chk(branch_record_enable_o, f == 0);
            rd(12'h0F4, 1'b0, f ? d & 32'h403C : d);
            rd(12'h0F6, 1'b0, 32'h1);
            chk(system_management_mode_o, 1'b1);
            sys_mgmt_int_i <= 1'b0;
            resume_i <= 1'b1;
            repeat (6) @(posedge clk_i);
            resume_i <= 1'b0;
            chk(global_counter_enables_o, f ? 8'hFF : v);
            chk(system_management_mode_o, 1'b0);
            rd(12'h0F4, 1'b0, d);
        end
        report_and_stop;
    end
endmodule
